// ==== logic/timer_defs.vh ====
// register offsets, field positions, reset values for the timer unit
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH
// byte addresses of the register words
`define OFS_STATUS_CONTROL 8'h00
`define OFS_COUNT_HIGH     8'h04
`define OFS_COUNT_LOW      8'h08
`define OFS_MODULO         8'h0c
`define OFS_CHANNEL_CFG    8'h10
`define OFS_IRQ_STATUS     8'h14
`define OFS_IRQ_MASK       8'h18
// status control field positions
`define SC_DIV_LSB         0
`define SC_CLEAR_BIT       4
`define SC_HALT_BIT        5
`define SC_ROLL_IE_BIT     6
`define SC_ROLL_FLAG_BIT   7
// channel config field positions
`define CC_CH0_OUT_BIT     0
`define CC_CH1_OUT_BIT     1
`define CC_CH0_BUF_BIT     2
`define CC_CH0_PWM_BIT     3
// reset values
`define RST_HALT           1'b1
`define RST_DIV            3'h0
`define RST_MODULO         16'hffff
`define RST_COUNT          16'h0000
// unavailable divide code
`define DIV_CODE_NONE      3'h7
// axi responses
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`endif

// ==== logic/prescaler.v ====
// free-running bus clock divider with a selectable tick tap
`include "timer_defs.vh"
module prescaler #(
	parameter WIDTH = 6
) (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       clear,
	input  wire       hold,
	input  wire [2:0] sel,
	output wire       tick
);
	reg  [WIDTH-1:0] div_reg;   // divider state
	reg  [WIDTH-1:0] div_next;  // next divider state
	reg  [WIDTH-1:0] tap_mask;  // low bits that must be all ones
	reg              tick_c;    // selected tap tick

	// -------------------------------------------------------------
	// divider
	// -------------------------------------------------------------
	// hold while halted, clear on counter clear strobe
	always @*
	begin
		div_next = div_reg + {{(WIDTH-1){1'b0}}, 1'b1};
		if (clear)
			div_next = {WIDTH{1'b0}};
		else if (hold)
			div_next = div_reg;
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
			div_reg <= {WIDTH{1'b0}};
		else
			div_reg <= div_next;
	end

	// -------------------------------------------------------------
	// tap select
	// -------------------------------------------------------------
	// tick when the low sel bits are all ones; code 7 gives no tick
	always @*
	begin
		tap_mask = ({WIDTH{1'b1}} >> (WIDTH - sel));
		tick_c   = 1'b0;
		if (sel == 3'h0)
			tick_c = 1'b1;
		else if (sel != `DIV_CODE_NONE)
			tick_c = ((div_reg & tap_mask) == tap_mask);
	end

	assign tick = tick_c & ~hold & ~clear;
endmodule // prescaler

// ==== logic/timer_counter_prescaler_core.v ====
// timer unit core: prescaler, counter, latched byte reads, axi4-lite slave
`include "timer_defs.vh"
// Contract
// - timer keeps counting during wait mode
// - registers unreachable during wait mode
// - enabled timer interrupt wakes from wait
// - stop mode freezes timer, preserves all state
// - resumes from preserved state after stop
// - each channel pin capture or compare
// - channel zero supports buffered compare, pwm; the buffer bit is never used, so compare is unbuffered
// - clear strobe resets counter and prescaler only; it also releases the low byte buffer
// - clear strobe self-clears, reads zero
// - halt plus clear holds counter at zero
// - divide select picks bus clock divide
// - counter bytes read-only, cleared by reset
// - high read latches low byte
// - buffer released only by low read; the clear strobe also releases it
// - rollover flag at modulo, gated interrupt
module timer_counter_prescaler_core #(
	parameter CNT_WIDTH = 16
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        wait_mode,
	input  wire        stop_mode,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        ch0_in,
	input  wire        ch1_in,
	output wire        ch0_out,
	output wire        ch0_oe,
	output wire        ch1_out,
	output wire        ch1_oe,
	output wire        capture0,
	output wire        capture1,
	output wire        irq
);
	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	reg  [CNT_WIDTH-1:0] count_reg;       // counter value
	reg  [CNT_WIDTH-1:0] modulo_reg;      // rollover value
	reg  [7:0]           low_buf_reg;     // latched low byte
	reg                  low_held_reg;    // low byte buffer in use
	reg  [2:0]           div_sel_reg;     // clock divide select
	reg                  halt_reg;        // counter halt
	reg                  clear_reg;       // counter clear strobe
	reg                  roll_ie_reg;     // rollover irq enable
	reg                  roll_flag_reg;   // rollover flag
	reg  [3:0]           chan_cfg_reg;    // channel pin config
	reg  [1:0]           irq_stat_reg;    // sticky events: roll, capture
	reg  [1:0]           irq_mask_reg;    // mask of irq status
	reg                  ch0_in_d_reg;    // previous channel zero input
	reg                  ch1_in_d_reg;    // previous channel one input
	reg                  aw_held_reg;     // write address taken
	reg                  w_held_reg;      // write data taken
	reg  [7:0]           aw_addr_reg;     // held write address
	reg  [31:0]          w_data_reg;      // held write data
	reg  [3:0]           w_strb_reg;      // held write strobes
	reg                  bvalid_reg;      // write response pending
	reg  [1:0]           bresp_reg;       // write response code
	reg                  rvalid_reg;      // read data pending
	reg  [31:0]          rdata_reg;       // read data
	reg  [1:0]           rresp_reg;       // read response code
	reg  [31:0]          rd_word;         // decoded read word
	reg                  rd_ok;           // read address mapped
	wire                 tick;            // prescaled counter tick
	wire                 run;             // timer clock active
	wire                 wr_fire;         // write performed this cycle
	wire                 rd_fire;         // read performed this cycle
	wire                 bus_open;        // cpu may reach registers
	wire                 wr_ok;           // write address mapped
	wire                 at_modulo;       // counter at rollover value
	wire                 wr_sc;           // status control written
	wire                 cap_evt;         // capture edge on any input pin
	wire [7:0]           sc_byte;         // status control read view

	// stop mode freezes the timer; wait mode keeps it running
	assign run      = ~stop_mode;
	assign bus_open = ~wait_mode & ~stop_mode;

	// -------------------------------------------------------------
	// prescaler
	// -------------------------------------------------------------
	// held while halted or stopped, cleared by the strobe
	prescaler #(
		.WIDTH (6)
	) u_prescaler (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (clear_reg),
		.hold    (halt_reg | ~run),
		.sel     (div_sel_reg),
		.tick    (tick)
	);

	// -------------------------------------------------------------
	// axi4-lite write path
	// -------------------------------------------------------------
	// address and data are taken once each and held until the write is done
	// in wait or stop the held write waits for the bus to reopen
	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
	assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg & bus_open;
	assign wr_ok   = (aw_addr_reg == `OFS_STATUS_CONTROL) | (aw_addr_reg == `OFS_MODULO) |
		(aw_addr_reg == `OFS_CHANNEL_CFG) | (aw_addr_reg == `OFS_IRQ_STATUS) |
		(aw_addr_reg == `OFS_IRQ_MASK);
	assign wr_sc   = wr_fire & (aw_addr_reg == `OFS_STATUS_CONTROL) & w_strb_reg[0];
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// capture address and data in either order, answer when both held
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				// transaction finishes, respond
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// control registers
	// -------------------------------------------------------------
	// written fields; the clear strobe lasts one cycle
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_sel_reg  <= `RST_DIV;
			halt_reg     <= `RST_HALT;
			clear_reg    <= 1'b0;
			roll_ie_reg  <= 1'b0;
			modulo_reg   <= `RST_MODULO;
			chan_cfg_reg <= 4'h0;
			irq_mask_reg <= 2'b00;
		end
		else
		begin
			// strobe drops once the counter has been reset
			clear_reg <= 1'b0;
			if (wr_sc)
			begin
				div_sel_reg <= w_data_reg[`SC_DIV_LSB+2:`SC_DIV_LSB];
				clear_reg   <= w_data_reg[`SC_CLEAR_BIT];
				halt_reg    <= w_data_reg[`SC_HALT_BIT];
				roll_ie_reg <= w_data_reg[`SC_ROLL_IE_BIT];
			end
			if (wr_fire && aw_addr_reg == `OFS_MODULO)
			begin
				if (w_strb_reg[0])
					modulo_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1])
					modulo_reg[15:8] <= w_data_reg[15:8];
			end
			if (wr_fire && aw_addr_reg == `OFS_CHANNEL_CFG && w_strb_reg[0])
				chan_cfg_reg <= w_data_reg[3:0];
			if (wr_fire && aw_addr_reg == `OFS_IRQ_MASK && w_strb_reg[0])
				irq_mask_reg <= w_data_reg[1:0];
		end
	end

	// -------------------------------------------------------------
	// counter
	// -------------------------------------------------------------
	// compare against the rollover value on every cycle
	assign at_modulo = (count_reg == modulo_reg);

	// clear wins, then halt, then ticks; halt with clear rests at zero
	always @(posedge aclk)
	begin
		if (!aresetn)
			count_reg <= `RST_COUNT;
		else if (clear_reg)
			count_reg <= `RST_COUNT;
		else if (tick && run)
		begin
			if (at_modulo)
				count_reg <= `RST_COUNT;
			else
				count_reg <= count_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// -------------------------------------------------------------
	// flags and interrupts
	// -------------------------------------------------------------
	// any level change on an input-mode pin counts as a capture
	assign cap_evt = (~chan_cfg_reg[`CC_CH0_OUT_BIT] & (ch0_in ^ ch0_in_d_reg)) |
		(~chan_cfg_reg[`CC_CH1_OUT_BIT] & (ch1_in ^ ch1_in_d_reg));

	// set beats clear; write one to clear
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			roll_flag_reg <= 1'b0;
			irq_stat_reg  <= 2'b00;
			ch0_in_d_reg  <= 1'b0;
			ch1_in_d_reg  <= 1'b0;
		end
		else if (run)
		begin
			ch0_in_d_reg <= ch0_in;
			ch1_in_d_reg <= ch1_in;
			if (tick && at_modulo && !clear_reg)
				roll_flag_reg <= 1'b1;
			else if (wr_sc && w_data_reg[`SC_ROLL_FLAG_BIT])
				roll_flag_reg <= 1'b0;
			irq_stat_reg[0] <= (tick & at_modulo & ~clear_reg) |
				(irq_stat_reg[0] & ~(wr_fire & (aw_addr_reg == `OFS_IRQ_STATUS) &
				w_data_reg[0]));
			irq_stat_reg[1] <= cap_evt |
				(irq_stat_reg[1] & ~(wr_fire & (aw_addr_reg == `OFS_IRQ_STATUS) &
				w_data_reg[1]));
		end
	end

	// level interrupt, also the wake request out of wait mode
	// a masked status bit keeps its value but raises nothing
	assign irq = (roll_flag_reg & roll_ie_reg) | (|(irq_stat_reg & irq_mask_reg));

	// -------------------------------------------------------------
	// channel pins
	// -------------------------------------------------------------
	// channel zero drives the pwm level whenever the pwm bit is set
	// an output enable high means the pin drives a compare level
	assign ch0_oe  = chan_cfg_reg[`CC_CH0_OUT_BIT];
	assign ch1_oe  = chan_cfg_reg[`CC_CH1_OUT_BIT];
	assign ch0_out = chan_cfg_reg[`CC_CH0_PWM_BIT] ? ~at_modulo : roll_flag_reg;
	assign ch1_out = roll_flag_reg;
	assign capture0 = ~chan_cfg_reg[`CC_CH0_OUT_BIT] & (ch0_in ^ ch0_in_d_reg);
	assign capture1 = ~chan_cfg_reg[`CC_CH1_OUT_BIT] & (ch1_in ^ ch1_in_d_reg);

	// -------------------------------------------------------------
	// axi4-lite read path
	// -------------------------------------------------------------
	// no new read while an answer is pending or the cpu sleeps
	// the counter bytes come straight from the counter, or from the buffer
	assign s_axi_arready = ~rvalid_reg & bus_open;
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign sc_byte = {roll_flag_reg, roll_ie_reg, halt_reg, 1'b0, 1'b0, div_sel_reg};
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// read decode; counter bytes are read-only views
	always @*
	begin
		rd_word = 32'h00000000;
		rd_ok   = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
			`OFS_STATUS_CONTROL: rd_word = {24'h000000, sc_byte};
			`OFS_COUNT_HIGH:     rd_word = {24'h000000, count_reg[15:8]};
			`OFS_COUNT_LOW:      rd_word = {24'h000000,
				low_held_reg ? low_buf_reg : count_reg[7:0]};
			`OFS_MODULO:         rd_word = {16'h0000, modulo_reg};
			`OFS_CHANNEL_CFG:    rd_word = {28'h0000000, chan_cfg_reg};
			`OFS_IRQ_STATUS:     rd_word = {30'h0, irq_stat_reg};
			`OFS_IRQ_MASK:       rd_word = {30'h0, irq_mask_reg};
			default:             rd_ok = 1'b0;
		endcase
	end

	// one-slot read response and low byte buffer
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg   <= 1'b0;
			rdata_reg    <= 32'h00000000;
			rresp_reg    <= `RESP_OKAY;
			low_buf_reg  <= 8'h00;
			low_held_reg <= 1'b0;
		end
		else
		begin
			if (rd_fire)
			begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_word;
				rresp_reg  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (rvalid_reg && s_axi_rready)
				rvalid_reg <= 1'b0;
			if (clear_reg)
				low_held_reg <= 1'b0;
			else if (rd_fire && {s_axi_araddr[7:2], 2'b00} == `OFS_COUNT_HIGH && !low_held_reg)
			begin
				low_buf_reg  <= count_reg[7:0];
				low_held_reg <= 1'b1;
			end
			else if (rd_fire && {s_axi_araddr[7:2], 2'b00} == `OFS_COUNT_LOW)
				low_held_reg <= 1'b0;
		end
	end
endmodule // timer_counter_prescaler_core

// ==== tb/cpu_bus_model.sv ====
// processor side model: register bus master with write and read tasks
module cpu_bus_model (
	input  wire logic        aclk,
	output var  logic [7:0]  s_axi_awaddr,
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output var  logic        s_axi_bready,
	output var  logic [7:0]  s_axi_araddr,
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output var  logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] last_resp; // response of the latest transfer
	// ----
	// idle bus at time zero
	// ----
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h0;
	end
	// ----
	// one write: address and data offered together, each dropped when taken
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		last_resp = s_axi_bresp;
	endtask
	// ----
	// one read: data and response taken at the rvalid edge
	// ----
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		last_resp = s_axi_rresp;
	endtask
endmodule // cpu_bus_model

// ==== tb/timer_counter_prescaler_core_chk.sv ====
// bus handshake and low-power checker for the timer unit core
module tcp_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----
	// handshake steps
	// ----
	sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
	sequence s_rd_done; s_axi_rvalid && s_axi_rready; endsequence
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// ----
	// properties
	// ----
	property p_ar_block; (wait_mode || stop_mode) |-> !s_axi_arready; endproperty
	property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
	property p_rd_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
	property p_rd_drop; s_rd_done |=> !s_axi_rvalid; endproperty
	property p_rd_single; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_wr_answer; s_wr_take ##0 !(wait_mode || stop_mode) |-> ##[1:2] s_axi_bvalid;
	endproperty
	property p_wr_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_wr_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_wr_single; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken in low power");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_rd_stand: assert property (p_rd_stand) else $error("rvalid dropped early");
	a_rd_drop: assert property (p_rd_drop) else $error("rvalid held after rready");
	a_rd_single: assert property (p_rd_single) else $error("second read taken");
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	a_wr_stand: assert property (p_wr_stand) else $error("bvalid dropped early");
	a_wr_drop: assert property (p_wr_drop) else $error("bvalid held after bready");
	a_wr_single: assert property (p_wr_single) else $error("second write taken");
endmodule // tcp_chk
bind timer_counter_prescaler_core tcp_chk chk_u (.aclk, .aresetn, .wait_mode, .stop_mode,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// ==== tb/timer_counter_prescaler_core_tb_top.sv ====
// self-checking bench for the timer unit core
`include "timer_defs.vh"
module timer_counter_prescaler_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// clock, modes, pins and bus wires
	// ----
	logic        aclk = 1'b0;
	logic        aresetn, wait_mode, stop_mode, ch0_in, ch1_in;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, irq;
	logic        ch0_out, ch0_oe, ch1_out, ch1_oe, capture0, capture1;
	logic [15:0] v;                               // counter value read back
	logic [31:0] cfg_set[4] = '{1, 2, 5, 9};      // channel modes tried
	int          n_fail = 0, comparisons = 0, cyc = 0, t0, e;
	always #50 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	timer_counter_prescaler_core dut_u (.aclk, .aresetn, .wait_mode, .stop_mode,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ch0_in, .ch1_in, .ch0_out, .ch0_oe, .ch1_out,
		.ch1_oe, .capture0, .capture1, .irq);
	cpu_bus_model bus_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ----
	// helpers
	// ----
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdcnt(output logic [15:0] c);
		logic [31:0] h, l;
		bus_u.rd(`OFS_COUNT_HIGH, h);
		bus_u.rd(`OFS_COUNT_LOW, l);
		c = {h[7:0], l[7:0]};
	endtask
	task automatic run0();
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h30);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h00);
	endtask
	task automatic look();
		repeat (2) @(posedge aclk);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----
	// watchdog
	// ----
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		report_and_stop();
	end
	// ----
	// tests
	// ----
	initial
	begin
		{aresetn, wait_mode, stop_mode, ch0_in, ch1_in} <= 5'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		bus_u.rd(`OFS_STATUS_CONTROL, d);
		chk("status_control", d, 32'h20);
		bus_u.rd(`OFS_MODULO, d);
		chk("modulo", d, 32'hffff);
		rdcnt(v);
		chk("count", v, 16'h0);
		bus_u.rd(8'h1c, d);
		chk("unmapped", bus_u.last_resp, `RESP_SLVERR);
		$display("test reset done");
		for (int c = 0; c < 8; c++)
		begin
			bus_u.wr(`OFS_STATUS_CONTROL, 32'h30);
			bus_u.wr(`OFS_STATUS_CONTROL, 32'(c));
			t0 = cyc;
			repeat (16 << c) @(posedge aclk);
			bus_u.wr(`OFS_STATUS_CONTROL, 32'h20 | c);
			e = (c == 7) ? 0 : (cyc - t0) >> c;
			rdcnt(v);
			chk("divide", (v + 2 >= e) && (v <= e + 2), 1);
		end
		$display("test divide done");
		run0();
		bus_u.rd(`OFS_COUNT_HIGH, d);
		repeat (50) @(posedge aclk);
		bus_u.rd(`OFS_COUNT_HIGH, d);
		repeat (50) @(posedge aclk);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h20);
		bus_u.rd(`OFS_COUNT_LOW, d);
		rdcnt(v);
		e = v - d[7:0];
		chk("latched_low", e >= 100 && e <= 130, 1);
		bus_u.wr(`OFS_MODULO, 32'h1234);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h23);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h33);
		bus_u.rd(`OFS_STATUS_CONTROL, d);
		chk("status_control", d, 32'h23);
		bus_u.rd(`OFS_MODULO, d);
		chk("modulo", d, 32'h1234);
		bus_u.wr(`OFS_COUNT_HIGH, 32'hff);
		chk("count_write", bus_u.last_resp, `RESP_SLVERR);
		rdcnt(v);
		chk("count", v, 16'h0);
		$display("test latch and clear done");
		run0();
		stop_mode <= 1'b1;
		repeat (300) @(posedge aclk);
		stop_mode <= 1'b0;
		repeat (20) @(posedge aclk);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h20);
		rdcnt(v);
		chk("stop_count", v >= 20 && v <= 30, 1);
		run0();
		wait_mode <= 1'b1;
		fork
			bus_u.rd(`OFS_IRQ_MASK, d);
			begin
				repeat (20) @(posedge aclk);
				chk("rvalid", s_axi_rvalid, 1'b0);
				wait_mode <= 1'b0;
			end
		join
		chk("irq_mask", d, 32'h0);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h20);
		rdcnt(v);
		chk("wait_count", v >= 22 && v <= 35, 1);
		$display("test low power done");
		bus_u.wr(`OFS_IRQ_MASK, 32'h0);
		bus_u.wr(`OFS_MODULO, 32'h5);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h30);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h40);
		wait_mode <= 1'b1;
		repeat (20) @(posedge aclk);
		chk("irq", irq, 1'b1);
		wait_mode <= 1'b0;
		bus_u.wr(`OFS_STATUS_CONTROL, 32'h60);
		bus_u.rd(`OFS_STATUS_CONTROL, d);
		chk("rollover_flag", d[7], 1'b1);
		rdcnt(v);
		chk("wrap", v <= 5, 1);
		bus_u.wr(`OFS_STATUS_CONTROL, 32'ha0);
		look();
		chk("irq", irq, 1'b0);
		bus_u.wr(`OFS_IRQ_MASK, 32'h1);
		look();
		chk("irq", irq, 1'b1);
		bus_u.wr(`OFS_IRQ_STATUS, 32'h1);
		look();
		chk("irq", irq, 1'b0);
		$display("test rollover done");
		foreach (cfg_set[i])
		begin
			bus_u.wr(`OFS_CHANNEL_CFG, cfg_set[i]);
			look();
			chk("pin_enable", {ch1_oe, ch0_oe}, cfg_set[i][1:0]);
			chk("pin_level", {ch1_out, ch0_out}, {1'b0, cfg_set[i][3] && v != 16'h5});
		end
		bus_u.wr(`OFS_CHANNEL_CFG, 32'h0);
		bus_u.wr(`OFS_IRQ_STATUS, 32'h3);
		{ch0_in, ch1_in} <= 2'h3;
		@(posedge aclk);
		chk("capture_pulse", {capture1, capture0}, 2'h3);
		@(posedge aclk);
		chk("capture_pulse", {capture1, capture0}, 2'h0);
		repeat (2) @(posedge aclk);
		bus_u.rd(`OFS_IRQ_STATUS, d);
		chk("capture", d[1], 1'b1);
		$display("test channels done");
		report_and_stop();
	end
endmodule // timer_counter_prescaler_core_tb_top
